/* File: logic/sdirc_pkg.sv */
// shared constants, register map and types for the transceiver reset controller
package sdirc_pkg;
    // timing
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned POR_WAIT_NS = 500;
    localparam int unsigned POR_CYC = (POR_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WAIT_TMO_US = 10;
    localparam int unsigned TMO_CYC = WAIT_TMO_US * CLK_MHZ;
    localparam int unsigned CNT_W = 12;
    localparam logic [3:0] RETRY_MAX = 4'h8;
    // apb register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // control field positions
    localparam int unsigned C_TX_DP = 0;
    localparam int unsigned C_RX_DP = 1;
    localparam int unsigned C_TX_SEL = 2;
    localparam int unsigned C_TX_MODE = 4;
    localparam int unsigned C_RX_MODE = 8;
    // command bit positions
    localparam int unsigned K_TX_FULL = 0;
    localparam int unsigned K_TX_PART = 1;
    localparam int unsigned K_RX_FULL = 2;
    localparam int unsigned K_RX_PART = 3;
    // reconfiguration port addresses and divider codes per mode
    localparam logic [8:0] RCFG_TX_ADDR = 9'h010;
    localparam logic [8:0] RCFG_RX_ADDR = 9'h011;
    localparam logic [4:0][15:0] RCFG_TBL = {16'h0004, 16'h0003, 16'h0002, 16'h0001, 16'h0000};
    // status word layout, msb first
    typedef struct packed {
        logic [10:0] zero;
        logic [3:0] pend;
        logic chg_act;
        logic [3:0] rx_retry;
        logic [3:0] tx_retry;
        logic rx_urdy;
        logic tx_urdy;
        logic rx_cdone;
        logic tx_cdone;
        logic rx_fail;
        logic tx_fail;
        logic rx_busy;
        logic tx_busy;
    } sdirc_stat_s;
    typedef enum logic [2:0] {
        ST_POR, ST_IDLE, ST_RST, ST_REFCLK, ST_LOCK, ST_DWAIT, ST_TMO, ST_FAIL
    } sdirc_seq_e;
    typedef enum logic [2:0] {CH_IDLE, CH_RCFG, CH_RST, CH_SEL, CH_REL, CH_WAIT} sdirc_ch_e;
endpackage

/* File: logic/sdirc_seq_if.sv */
// link between the controller core and one section reset sequencer
interface sdirc_seq_if;
    logic req_full;
    logic req_part;
    logic hold;
    logic refclk_ok;
    logic pll_lock;
    logic rst_done;
    logic pll_rst;
    logic sec_rst;
    logic urdy;
    logic finish;
    logic fail;
    logic busy;
    logic [3:0] retry;
    modport ctrl (
        output req_full, req_part, hold, refclk_ok, pll_lock, rst_done,
        input pll_rst, sec_rst, urdy, finish, fail, busy, retry
    );
    modport seq (
        input req_full, req_part, hold, refclk_ok, pll_lock, rst_done,
        output pll_rst, sec_rst, urdy, finish, fail, busy, retry
    );
endinterface

/* File: logic/sdirc_seq.sv */
// reset sequencer for one transceiver section and its pll
module sdirc_seq
    import sdirc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // controller side
    sdirc_seq_if.seq sif
);
    sdirc_seq_e st_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic full_reg;
    logic idle_like;
    logic last;
    logic tmo;
    logic adv;
    logic start_full;
    logic start_any;

    // sequence decisions
    assign idle_like = (st_reg == ST_IDLE) || (st_reg == ST_FAIL);
    assign last = (sif.retry == RETRY_MAX - 4'h1);
    assign tmo = (cnt_reg == CNT_W'(TMO_CYC - 1));
    assign adv = ((st_reg == ST_REFCLK) && sif.refclk_ok) || ((st_reg == ST_LOCK) && sif.pll_lock)
        || ((st_reg == ST_DWAIT) && sif.rst_done && sif.urdy);
    assign start_full = ((st_reg == ST_POR) && (cnt_reg == CNT_W'(POR_CYC - 1)))
        || (idle_like && sif.req_full) || ((st_reg == ST_TMO) && !last && full_reg);
    assign start_any = start_full || (idle_like && sif.req_part)
        || ((st_reg == ST_TMO) && !last);
    assign sif.busy = !idle_like;

    // state walk
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_reg <= ST_POR;
        else if (start_any)
            st_reg <= ST_RST;
        else
            case (st_reg)
                ST_RST: if (!sif.hold) st_reg <= full_reg ? ST_REFCLK : ST_LOCK;
                ST_REFCLK: if (adv) st_reg <= ST_LOCK; else if (tmo) st_reg <= ST_TMO;
                ST_LOCK: if (adv) st_reg <= ST_DWAIT; else if (tmo) st_reg <= ST_TMO;
                ST_DWAIT: if (adv) st_reg <= ST_IDLE; else if (tmo) st_reg <= ST_TMO;
                ST_TMO: st_reg <= ST_FAIL;
                default: st_reg <= st_reg;
            endcase
    end

    // wait and timeout counter
    always_ff @(posedge clk_i)
    begin
        if (rst_i || start_any || adv || tmo)
            cnt_reg <= '0;
        else if ((st_reg == ST_POR) || (st_reg == ST_REFCLK) || (st_reg == ST_LOCK)
            || (st_reg == ST_DWAIT))
            cnt_reg <= cnt_reg + 1'b1;
    end

    // reset and ready outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            full_reg <= 1'b0;
            sif.pll_rst <= 1'b0;
            sif.sec_rst <= 1'b0;
            sif.urdy <= 1'b0;
        end
        else if (start_any)
        begin
            full_reg <= start_full;
            sif.pll_rst <= start_full;
            sif.sec_rst <= 1'b1;
            sif.urdy <= 1'b0;
        end
        else if ((st_reg == ST_REFCLK) && adv)
            sif.pll_rst <= 1'b0;
        else if ((st_reg == ST_LOCK) && adv)
            sif.sec_rst <= 1'b0;
        else if (st_reg == ST_DWAIT)
            sif.urdy <= 1'b1;
    end

    // retry count, failure and finish pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sif.retry <= 4'h0;
            sif.fail <= 1'b0;
            sif.finish <= 1'b0;
        end
        else
        begin
            sif.finish <= adv && (st_reg == ST_DWAIT) || ((st_reg == ST_TMO) && last);
            if (start_any && (st_reg != ST_TMO))
                sif.retry <= 4'h0;
            else if ((st_reg == ST_TMO) && !last)
                sif.retry <= sif.retry + 4'h1;
            if (start_any)
                sif.fail <= 1'b0;
            else if ((st_reg == ST_TMO) && last)
                sif.fail <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence lock_seen_s;
        $past(sif.pll_lock) && !$past(sif.pll_rst);
    endsequence
    sec_after_lock_a: assert property ($fell(sif.sec_rst) |-> lock_seen_s)
        else $error("section reset released without pll lock");
    urdy_after_rst_a: assert property ($rose(sif.urdy) |-> !sif.sec_rst && $past(!sif.sec_rst))
        else $error("user ready raised while section in reset");
    retry_step_a: assert property ((st_reg == ST_TMO) && !last |=>
        (sif.retry == $past(sif.retry) + 4'h1) && (st_reg == ST_RST))
        else $error("timeout did not count a retry and resume");
    part_no_pll_a: assert property ((st_reg == ST_RST) && !full_reg |-> !sif.pll_rst)
        else $error("partial reset touched the pll");
    por_full_a: assert property ((st_reg == ST_POR) && (cnt_reg == CNT_W'(POR_CYC - 1))
        |=> sif.pll_rst && sif.sec_rst)
        else $error("power-on sequence did not reset pll and section");
endmodule // sdirc_seq

/* File: logic/sdirc_top.sv */
// transceiver reset and dynamic change controller with apb registers
// Overview of operation
// - pll reset also resets transmit section
// - select change: reset, switch source, release
// - change done only after transmit reset done
// - divider rewrite followed by transmit reset
// - per-channel transmit clock source select
// - transmit datapath reset leaves transceiver alone
// - full transmit reset: pll first, section after lock
// - transmit-only reset waits for pll lock
// - pll reset also resets receive section
// - receive mode change: update, then reset
// - receive datapath reset leaves transceiver alone
// - full receive reset: pll first, section after lock
// - receive-only reset waits for pll lock
// - user ready follows section reset release
// - waits time out, retry, then fail
module sdirc_top
    import sdirc_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // transmit section
    input wire logic TX_REFCLK_STABLE_I,
    input wire logic TX_PLL_LOCK_I,
    input wire logic TX_RESET_DONE_I,
    output logic TX_PLL_RESET_O,
    output logic TX_SEC_RESET_O,
    output logic TX_USER_READY_O,
    output logic TX_SYSCLK_SEL_O,
    output logic TX_CHANGE_DONE_O,
    output logic TX_DP_RST_O,
    // receive section
    input wire logic RX_REFCLK_STABLE_I,
    input wire logic RX_PLL_LOCK_I,
    input wire logic RX_RESET_DONE_I,
    output logic RX_PLL_RESET_O,
    output logic RX_SEC_RESET_O,
    output logic RX_USER_READY_O,
    output logic [2:0] RX_RATE_O,
    output logic RX_CHANGE_DONE_O,
    output logic RX_DP_RST_O,
    // dynamic reconfiguration port master
    output logic RCFG_EN_O,
    output logic RCFG_WE_O,
    output logic [8:0] RCFG_ADDR_O,
    output logic [15:0] RCFG_DI_O,
    input wire logic RCFG_RDY_I
);
    sdirc_seq_if tx_if ();
    sdirc_seq_if rx_if ();
    sdirc_ch_e ch_reg;
    logic [31:0] ctrl_reg;
    logic [3:0] pend_reg;
    logic [3:0] take;
    logic [3:0] cmd;
    logic ch_rx_reg;
    logic ch_chg_reg;
    logic [2:0] tx_mode_reg;
    logic apb_wr;
    logic tx_sel_chg;
    logic tx_mode_chg;
    logic rx_mode_chg;
    logic tx_start;
    logic rx_start;
    logic [2:0] new_mode;
    sdirc_stat_s stat;

    // transmit and receive sequencers
    sdirc_seq u_tx_seq (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .sif(tx_if.seq)
    );
    sdirc_seq u_rx_seq (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .sif(rx_if.seq)
    );

    // transceiver status into the sequencers
    assign tx_if.refclk_ok = TX_REFCLK_STABLE_I;
    assign tx_if.pll_lock = TX_PLL_LOCK_I;
    assign tx_if.rst_done = TX_RESET_DONE_I;
    assign rx_if.refclk_ok = RX_REFCLK_STABLE_I;
    assign rx_if.pll_lock = RX_PLL_LOCK_I;
    assign rx_if.rst_done = RX_RESET_DONE_I;

    // sequencer outputs are flops inside the sequencers
    assign TX_PLL_RESET_O = tx_if.pll_rst;
    assign TX_SEC_RESET_O = tx_if.sec_rst;
    assign TX_USER_READY_O = tx_if.urdy;
    assign RX_PLL_RESET_O = rx_if.pll_rst;
    assign RX_SEC_RESET_O = rx_if.sec_rst;
    assign RX_USER_READY_O = rx_if.urdy;

    // apb write strobe and command pulses
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    assign cmd = (apb_wr && (PADDR_I == REG_CMD)) ? PWDATA_I[3:0] : 4'h0;

    // pending change detection against applied settings
    assign tx_sel_chg = ctrl_reg[C_TX_SEL] != TX_SYSCLK_SEL_O;
    assign tx_mode_chg = ctrl_reg[C_TX_MODE +: 3] != tx_mode_reg;
    assign rx_mode_chg = ctrl_reg[C_RX_MODE +: 3] != RX_RATE_O;
    assign tx_start = (ch_reg == CH_IDLE) && !tx_if.busy && (pend_reg[1:0] == 2'b00)
        && (tx_sel_chg || tx_mode_chg);
    assign rx_start = (ch_reg == CH_IDLE) && !rx_if.busy && (pend_reg[3:2] == 2'b00)
        && !tx_start && rx_mode_chg;
    assign new_mode = rx_start ? ctrl_reg[C_RX_MODE +: 3] : ctrl_reg[C_TX_MODE +: 3];

    // reset requests taken by the change engine
    always_comb
    begin
        take = 4'h0;
        if (tx_start || rx_start)
            take = 4'h0; // a starting change owns the engine this cycle
        else if ((ch_reg == CH_IDLE) && !tx_if.busy && pend_reg[K_TX_FULL])
            take[K_TX_FULL] = 1'b1;
        else if ((ch_reg == CH_IDLE) && !tx_if.busy && pend_reg[K_TX_PART])
            take[K_TX_PART] = 1'b1;
        else if ((ch_reg == CH_IDLE) && !rx_if.busy && pend_reg[K_RX_FULL])
            take[K_RX_FULL] = 1'b1;
        else if ((ch_reg == CH_IDLE) && !rx_if.busy && pend_reg[K_RX_PART])
            take[K_RX_PART] = 1'b1;
    end

    // pending request flags, a new request wins over the take
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
            pend_reg <= 4'h0;
        else
            pend_reg <= (pend_reg & ~take) | cmd;
    end

    // control register
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
            ctrl_reg <= CTRL_RST;
        else if (apb_wr && (PADDR_I == REG_CTRL))
            ctrl_reg <= {21'h0, PWDATA_I[10:8], 1'b0, PWDATA_I[6:4], 1'b0, PWDATA_I[2:0]};
    end

    // datapath resets come only from control bits
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            TX_DP_RST_O <= 1'b0;
            RX_DP_RST_O <= 1'b0;
        end
        else
        begin
            TX_DP_RST_O <= ctrl_reg[C_TX_DP];
            RX_DP_RST_O <= ctrl_reg[C_RX_DP];
        end
    end

    // change engine: reconfigure, reset, switch source, release, wait
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            ch_reg <= CH_IDLE;
            ch_rx_reg <= 1'b0;
            ch_chg_reg <= 1'b0;
        end
        else
            case (ch_reg)
                CH_IDLE:
                begin
                    ch_chg_reg <= tx_start || rx_start;
                    ch_rx_reg <= rx_start || take[K_RX_FULL] || take[K_RX_PART];
                    if (tx_start && !tx_mode_chg)
                        ch_reg <= CH_RST;
                    else if (tx_start || rx_start)
                        ch_reg <= CH_RCFG;
                    else if (take != 4'h0)
                        ch_reg <= CH_WAIT;
                end
                CH_RCFG: if (RCFG_RDY_I) ch_reg <= CH_RST;
                CH_RST: ch_reg <= CH_SEL;
                CH_SEL: ch_reg <= CH_REL;
                CH_REL: ch_reg <= CH_WAIT;
                CH_WAIT:
                begin
                    if ((ch_rx_reg ? rx_if.finish : tx_if.finish))
                        ch_reg <= CH_IDLE;
                end
                default: ch_reg <= CH_IDLE;
            endcase
    end

    // sequencer requests and reset hold
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            tx_if.req_full <= 1'b0;
            tx_if.req_part <= 1'b0;
            rx_if.req_full <= 1'b0;
            rx_if.req_part <= 1'b0;
            tx_if.hold <= 1'b0;
            rx_if.hold <= 1'b0;
        end
        else
        begin
            tx_if.req_full <= take[K_TX_FULL];
            tx_if.req_part <= take[K_TX_PART] || ((ch_reg == CH_RST) && !ch_rx_reg);
            rx_if.req_full <= take[K_RX_FULL];
            rx_if.req_part <= take[K_RX_PART] || ((ch_reg == CH_RST) && ch_rx_reg);
            tx_if.hold <= (ch_reg == CH_RST || ch_reg == CH_SEL) && !ch_rx_reg;
            rx_if.hold <= (ch_reg == CH_RST || ch_reg == CH_SEL) && ch_rx_reg;
        end
    end

    // applied clock source, switched inside the reset window; modes applied at change start
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            TX_SYSCLK_SEL_O <= 1'b0;
            tx_mode_reg <= 3'h0;
            RX_RATE_O <= 3'h0;
        end
        else
        begin
            // one cycle after the section reset is up, so the switch sits inside it
            if ((ch_reg == CH_REL) && !ch_rx_reg)
                TX_SYSCLK_SEL_O <= ctrl_reg[C_TX_SEL];
            if (tx_start && tx_mode_chg)
                tx_mode_reg <= ctrl_reg[C_TX_MODE +: 3];
            if (rx_start)
                RX_RATE_O <= ctrl_reg[C_RX_MODE +: 3];
        end
    end

    // change done flags
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            TX_CHANGE_DONE_O <= 1'b1;
            RX_CHANGE_DONE_O <= 1'b1;
        end
        else
        begin
            if (tx_start)
                TX_CHANGE_DONE_O <= 1'b0;
            else if ((ch_reg == CH_WAIT) && ch_chg_reg && !ch_rx_reg && tx_if.finish
                && !tx_if.fail)
                TX_CHANGE_DONE_O <= 1'b1;
            if (rx_start)
                RX_CHANGE_DONE_O <= 1'b0;
            else if ((ch_reg == CH_WAIT) && ch_chg_reg && ch_rx_reg && rx_if.finish
                && !rx_if.fail)
                RX_CHANGE_DONE_O <= 1'b1;
        end
    end

    // reconfiguration port write of the divider for the new mode
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            RCFG_EN_O <= 1'b0;
            RCFG_WE_O <= 1'b0;
            RCFG_ADDR_O <= 9'h000;
            RCFG_DI_O <= 16'h0000;
        end
        else
        begin
            RCFG_EN_O <= (tx_start && tx_mode_chg) || rx_start;
            RCFG_WE_O <= (tx_start && tx_mode_chg) || rx_start;
            if ((tx_start && tx_mode_chg) || rx_start)
            begin
                RCFG_ADDR_O <= rx_start ? RCFG_RX_ADDR : RCFG_TX_ADDR;
                RCFG_DI_O <= (new_mode > 3'h4) ? RCFG_TBL[4] : RCFG_TBL[new_mode];
            end
        end
    end

    // status word
    always_comb
    begin
        stat = '0;
        stat.tx_busy = tx_if.busy;
        stat.rx_busy = rx_if.busy;
        stat.tx_fail = tx_if.fail;
        stat.rx_fail = rx_if.fail;
        stat.tx_cdone = TX_CHANGE_DONE_O;
        stat.rx_cdone = RX_CHANGE_DONE_O;
        stat.tx_urdy = tx_if.urdy;
        stat.rx_urdy = rx_if.urdy;
        stat.tx_retry = tx_if.retry;
        stat.rx_retry = rx_if.retry;
        stat.chg_act = (ch_reg != CH_IDLE);
        stat.pend = pend_reg;
    end

    // apb answer: ready in the first access cycle, read data and error set up
    always_ff @(posedge SYS_CLK_I)
    begin
        if (RST_I)
        begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end
        else
        begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            if (PSEL_I && !PENABLE_I)
            begin
                PSLVERR_O <= !((PADDR_I == REG_CTRL) || (PADDR_I == REG_CMD)
                    || (PADDR_I == REG_STAT));
                case (PADDR_I)
                    REG_CTRL: PRDATA_O <= ctrl_reg;
                    REG_STAT: PRDATA_O <= stat;
                    default: PRDATA_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    sequence sel_window_s;
        TX_SEC_RESET_O && $past(TX_SEC_RESET_O);
    endsequence
    sel_in_reset_a: assert property ($changed(TX_SYSCLK_SEL_O) |-> sel_window_s)
        else $error("clock source switched outside section reset");
    sel_release_a: assert property ($changed(TX_SYSCLK_SEL_O) |-> ##2 !tx_if.hold)
        else $error("hold not dropped after source switch");
    cdone_clear_a: assert property (tx_start |=> !TX_CHANGE_DONE_O)
        else $error("change done not cleared at change start");
    cdone_cause_a: assert property ($rose(TX_CHANGE_DONE_O) |-> $past(tx_if.finish))
        else $error("change done without reset completion");
    rcfg_first_a: assert property (RCFG_EN_O |-> !rx_if.hold && !tx_if.hold)
        else $error("reconfiguration issued after reset began");
    pend_keep_a: assert property (cmd[K_TX_FULL] |=> pend_reg[K_TX_FULL])
        else $error("request lost while pending");
    dp_rst_a: assert property (TX_DP_RST_O |-> $past(ctrl_reg[C_TX_DP]))
        else $error("datapath reset from wrong source");
endmodule // sdirc_top

/* File: sim/sdirc_xcvr.sv */
// behavioural transceiver section: pll lock, reset done and reconfig ready
module sdirc_xcvr
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // controls from the controller
    input wire logic pll_rst_i,
    input wire logic sec_rst_i,
    input wire logic rcfg_en_i,
    input wire logic [3:0] lat_i,
    // status back to the controller
    output logic lock_o,
    output logic done_o,
    output logic rdy_o
);
    logic [3:0] lk_cnt, dn_cnt, rc_cnt;
    // lock drops in pll reset and comes back after lat_i cycles
    always_ff @(posedge clk_i)
    begin
        lk_cnt <= (rst_i || pll_rst_i) ? lat_i : lk_cnt - 4'(lk_cnt != 4'h0);
        lock_o <= !(rst_i || pll_rst_i) && lk_cnt == 4'h0;
    end
    // reset done only once the section reset ended and lock was held for a while
    always_ff @(posedge clk_i)
    begin
        dn_cnt <= (rst_i || sec_rst_i || !lock_o) ? lat_i : dn_cnt - 4'(dn_cnt != 4'h0);
        done_o <= !(rst_i || sec_rst_i || !lock_o) && dn_cnt == 4'h0;
    end
    // reconfig port answers with a one-cycle ready pulse after lat_i cycles
    always_ff @(posedge clk_i)
    begin
        rc_cnt <= rst_i ? 4'h0 : rcfg_en_i ? lat_i : rc_cnt - 4'(rc_cnt != 4'h0);
        rdy_o <= rc_cnt == 4'h1;
    end
endmodule // sdirc_xcvr

/* File: sim/sdirc_top_test.sv */
// self-checking bench for the transceiver reset controller
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
`define WAITFOR(c) begin int k; k = 0; while (!(c) && k < 5000) begin @(posedge clk); \
    k++; end `CHK("wait", 1, k < 5000) end
module sdirc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sdirc_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} sdirc_note_s;
    sdirc_note_s notes[$];
    sdirc_note_s nt;
    int errors = 0, num_checks = 0;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, PRDATA_O;
    logic tx_ref = 0, rx_ref = 0;
    int txp = 0, rxp = 0, tx0 = 0, rx0 = 0, cap = 0;
    logic [3:0] lat = 4'h3;
    logic PREADY_O, PSLVERR_O, TX_PLL_RESET_O, TX_SEC_RESET_O, TX_USER_READY_O, TX_SYSCLK_SEL_O;
    logic TX_CHANGE_DONE_O, TX_DP_RST_O, RX_PLL_RESET_O, RX_SEC_RESET_O, RX_USER_READY_O;
    logic RX_CHANGE_DONE_O, RX_DP_RST_O, RCFG_EN_O, RCFG_WE_O, RCFG_RDY_I;
    logic TX_PLL_LOCK_I, TX_RESET_DONE_I, RX_PLL_LOCK_I, RX_RESET_DONE_I;
    logic [2:0] RX_RATE_O;
    logic [8:0] RCFG_ADDR_O;
    logic [15:0] RCFG_DI_O;
    // clock
    always #2.5 clk = ~clk;
    sdirc_top i_sdirc_top (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O, .PREADY_O, .PSLVERR_O,
        .TX_REFCLK_STABLE_I(tx_ref), .TX_PLL_LOCK_I, .TX_RESET_DONE_I, .TX_PLL_RESET_O,
        .TX_SEC_RESET_O, .TX_USER_READY_O, .TX_SYSCLK_SEL_O, .TX_CHANGE_DONE_O, .TX_DP_RST_O,
        .RX_REFCLK_STABLE_I(rx_ref), .RX_PLL_LOCK_I, .RX_RESET_DONE_I, .RX_PLL_RESET_O,
        .RX_SEC_RESET_O, .RX_USER_READY_O, .RX_RATE_O, .RX_CHANGE_DONE_O, .RX_DP_RST_O,
        .RCFG_EN_O, .RCFG_WE_O, .RCFG_ADDR_O, .RCFG_DI_O, .RCFG_RDY_I);
    sdirc_xcvr i_sdirc_xcvr (.clk_i(clk), .rst_i(rst), .pll_rst_i(TX_PLL_RESET_O),
        .sec_rst_i(TX_SEC_RESET_O), .rcfg_en_i(RCFG_EN_O), .lat_i(lat), .lock_o(TX_PLL_LOCK_I),
        .done_o(TX_RESET_DONE_I), .rdy_o(RCFG_RDY_I));
    sdirc_xcvr i_sdirc_xcvr_rx (.clk_i(clk), .rst_i(rst), .pll_rst_i(RX_PLL_RESET_O),
        .sec_rst_i(RX_SEC_RESET_O), .rcfg_en_i(1'b0), .lat_i(lat), .lock_o(RX_PLL_LOCK_I),
        .done_o(RX_RESET_DONE_I), .rdy_o());
    // one apb transfer; a read leaves its expected word in the queue
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m = 32'h0, input logic e = 0);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr)
            notes.push_back('{d, m, e});
        @(posedge clk) penable <= 1;
        do @(posedge clk); while (PREADY_O !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    // read watcher and sequence checks on the transceiver pins
    always @(posedge clk)
    begin
        if (psel && penable && PREADY_O && !pwrite && notes.size() > 0)
        begin
            nt = notes.pop_front();
            `CHK("prdata", nt.d & nt.m, PRDATA_O & nt.m)
            `CHK("pslverr", nt.e, PSLVERR_O)
        end
        if ($fell(TX_SEC_RESET_O) && !rst) `CHK("tx lock", 1'b1, TX_PLL_LOCK_I)
        if ($fell(RX_SEC_RESET_O) && !rst) `CHK("rx lock", 1'b1, RX_PLL_LOCK_I)
        if ($rose(TX_USER_READY_O) && !rst) `CHK("tx urdy", 1'b0, TX_SEC_RESET_O)
        if ($rose(RX_USER_READY_O) && !rst) `CHK("rx urdy", 1'b0, RX_SEC_RESET_O)
        if ($changed(TX_SYSCLK_SEL_O) && !rst) `CHK("sel in reset", 1'b1, TX_SEC_RESET_O)
        if ($rose(TX_CHANGE_DONE_O) && !rst) `CHK("chg done", 1'b1, TX_RESET_DONE_I)
        // running count of pll reset cycles, only this process writes it
        if (!rst)
        begin
            txp <= txp + int'(TX_PLL_RESET_O);
            rxp <= rxp + int'(RX_PLL_RESET_O);
        end
    end
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #400000;
        errors++;
        conclude();
    end
    // main sequence
    initial
    begin
        void'($urandom(32'hAAAE));
        repeat (3) @(posedge clk);
        rst <= 0;
        `CHK("chg rst", 1'b1, TX_CHANGE_DONE_O)
        repeat (140) @(posedge clk);
        `CHK("tx pll", 1'b1, TX_PLL_RESET_O & TX_SEC_RESET_O)
        `CHK("rx pll", 1'b1, RX_PLL_RESET_O & RX_SEC_RESET_O)
        tx_ref <= 1;
        rx_ref <= 1;
        `WAITFOR(TX_USER_READY_O && RX_USER_READY_O && TX_RESET_DONE_I && RX_RESET_DONE_I)
        apb(0, REG_STAT, 32'hF0, 32'hFF);
        apb(0, 8'h0C, 32'h0, 32'hFFFFFFFF, 1);
        apb(0, REG_CMD, 32'h0, 32'hF);
        // full tx reset waits for refclk, rx-only request stays pending
        tx_ref <= 0;
        tx0 = txp;
        rx0 = rxp;
        apb(1, REG_CMD, 32'h1);
        apb(1, REG_CMD, 32'h8);
        repeat (30) @(posedge clk);
        `CHK("tx held", 1'b1, TX_PLL_RESET_O & TX_SEC_RESET_O)
        tx_ref <= 1;
        `WAITFOR(RX_SEC_RESET_O)
        `CHK("rx pend", 2'b10, {txp != tx0, rxp != rx0})
        `WAITFOR(RX_USER_READY_O)
        tx0 = txp;
        apb(1, REG_CMD, 32'h2);
        `WAITFOR(TX_SEC_RESET_O)
        `WAITFOR(TX_USER_READY_O)
        `CHK("tx part", 1'b0, txp != tx0)
        // datapath resets leave the transceiver alone
        apb(1, REG_CTRL, 32'h3);
        @(posedge clk);
        `CHK("dp", 4'hC, {TX_DP_RST_O, RX_DP_RST_O, TX_SEC_RESET_O, RX_SEC_RESET_O})
        apb(1, REG_CTRL, 32'h4);
        `WAITFOR(!TX_CHANGE_DONE_O)
        `WAITFOR(TX_CHANGE_DONE_O)
        `CHK("sel", 1'b1, TX_SYSCLK_SEL_O)
        // tx and rx modes 1 to 4 plus two codes above 12g, random transceiver latency
        for (int i = 1; i < 7; i++)
        begin
            cap = (i > 4) ? 4 : i;
            lat <= 4'($urandom_range(9, 2));
            apb(1, REG_CTRL, 32'(i) * 32'h110 + 32'h4);
            `WAITFOR(RCFG_EN_O && RCFG_WE_O)
            `CHK("tx di", {RCFG_TX_ADDR, RCFG_TBL[cap]}, {RCFG_ADDR_O, RCFG_DI_O})
            `CHK("tx chg", 1'b0, TX_CHANGE_DONE_O)
            `WAITFOR(TX_SEC_RESET_O)
            `WAITFOR(TX_CHANGE_DONE_O)
            `WAITFOR(RCFG_EN_O)
            `CHK("rx di", {RCFG_RX_ADDR, RCFG_TBL[cap]}, {RCFG_ADDR_O, RCFG_DI_O})
            `CHK("rate", 3'(i), RX_RATE_O)
            `WAITFOR(RX_SEC_RESET_O)
            `WAITFOR(RX_CHANGE_DONE_O && RX_USER_READY_O)
        end
        // eight timeouts without refclk end in fail, a new request recovers
        rx_ref <= 0;
        apb(1, REG_CMD, 32'h4);
        repeat (17000) @(posedge clk);
        apb(0, REG_STAT, 32'h8, 32'h8);
        rx_ref <= 1;
        apb(1, REG_CMD, 32'h4);
        `WAITFOR(RX_PLL_RESET_O)
        `WAITFOR(RX_USER_READY_O && RX_RESET_DONE_I)
        apb(0, REG_STAT, 32'h0, 32'hF);
        conclude();
    end
endmodule // sdirc_top_test
